// file: hdl/see_pkg.sv
package see_pkg;
  // core clock
  localparam int CLK_PERIOD_NS   = 8;
  // least time select must stay low between instructions
  localparam int CS_LOW_MIN_NS   = 250;
  localparam int CS_LOW_MIN_CYC  =
    (CS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // self-timed programming time, plain default
  localparam int PROG_TIME_NS    = 2000;
  localparam int PROG_CYC        = PROG_TIME_NS / CLK_PERIOD_NS;
  // output_valid_delay: core cycles from link clock pin edge to data out
  localparam int OUT_VALID_DELAY_CYC = 4;
  // instruction codes, after the start bit
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // word organisation variants
  localparam int ORG_STRAP = 0;
  localparam int ORG_FIX8  = 1;
  localparam int ORG_FIX16 = 2;
  // erased word value
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // bits per word
  localparam int WBITS8  = 8;
  localparam int WBITS16 = 16;
  // instruction sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_WDATA, ST_READ, ST_DONE
  } see_state_type;
endpackage

// file: hdl/see_top.sv
// Operation
// - start, opcode, address, data sampled on clock
// - read bits driven in step with clock
// - status shown on select rise after programming
// - select low throughout: output stays high-impedance
// - status after cycle finishes reads high
// - start bit then select low clears status
// - strap high selects 16-bit words
// - strap low selects 8-bit words
// - fixed variants ignore the strap pin
// - status low while busy, high when ready
// - select low resets control logic
// - read: dummy zero, word, then next location
// - capture and shift out on rising clock

// small first-word-fall-through queue with valid/ready on both sides
module see_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] store_q [DEPTH];  // entries
  logic [PW:0]  wr_q;             // write pointer with wrap bit
  logic [PW:0]  rd_q;             // read pointer with wrap bit
  logic         push;
  logic         pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o  = !((wr_q[PW] != rd_q[PW]) &&
                         (wr_q[PW-1:0] == rd_q[PW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o  = store_q[rd_q[PW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // storage needs no reset, it is only read when valid
  always_ff @(posedge ref_clk_i) begin
    if (push) store_q[wr_q[PW-1:0]] <= in_data_i;
  end
endmodule

// serial memory slave: instruction decode, read shifting, status output
module see_top #(
  parameter int ORG_MODE   = see_pkg::ORG_STRAP, // variant selection
  parameter int AW         = 8,                  // byte address bits
  parameter int FIFO_DEPTH = 8,                  // pending programs
  parameter int PROG_CYC   = see_pkg::PROG_CYC   // programming cycles
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // serial pins from the master
  input  wire logic cs_i,
  input  wire logic sclk_i,
  input  wire logic serial_data_in_i,
  // organisation strap
  input  wire logic word_width_strap_i,
  // serial data output as a tri-state pin
  output logic      do_o,
  output logic      do_oe_o
);
  localparam int FW = AW + 17;  // x16 flag, byte address, data

  logic [1:0]  cs_s, clk_s, di_s, org_s;  // two-stage synchronisers
  logic        cs_d_q;                    // select, one cycle late
  logic        clk_d_q;                   // link clock, one cycle late
  logic        rise, cs_rise, cs_fall;
  logic [7:0]  cslow_q;                   // select low time, saturating
  see_pkg::see_state_type st_q;
  logic [4:0]  cnt_q;                     // bit counter
  logic        x16_q;                     // organisation of this instruction
  logic        x16_now;
  logic [1:0]  opc_q;
  logic [AW-1:0] addr_q;                  // address shifted in
  logic [AW-1:0] baddr_q;                 // byte address of the word
  logic [AW-1:0] nxt_addr, nxt_baddr;
  logic [15:0] wd_q;                      // write data shifted in
  logic [15:0] sh_q;                      // read shifter
  logic        ld_q;                      // load shifter next cycle
  logic        rd_on_q, rd_bit_q;         // read drive and bit
  logic        cmt_q;                     // program waiting for select fall
  logic        stat_q;                    // status display active
  logic        pend_q;                    // program initiated, not cleared
  logic        clr_arm_q;                 // start bit seen during status
  logic [15:0] rd_word;
  logic [4:0]  wbits_m1;
  logic        busy;
  logic        do_q, do_oe_q;
  logic [7:0]  mem_q [2**AW];             // the array
  // queue and programming engine
  logic          f_in_rdy, f_out_vld, f_out_rdy, push;
  logic [FW-1:0] f_in, f_out, prog_q;
  logic [$clog2(PROG_CYC+1)-1:0] timer_q;

  // synchronisers: only the second stage is read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_s  <= '0;
      clk_s <= '0;
      di_s  <= '0;
      org_s <= '0;
    end else begin
      cs_s  <= {cs_s[0], cs_i};
      clk_s <= {clk_s[0], sclk_i};
      di_s  <= {di_s[0], serial_data_in_i};
      org_s <= {org_s[0], word_width_strap_i};
    end
  end

  // edge detection on the synchronised levels
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_d_q  <= 1'b0;
      clk_d_q <= 1'b0;
    end else begin
      cs_d_q  <= cs_s[1];
      clk_d_q <= clk_s[1];
    end
  end

  assign rise    = clk_s[1] && !clk_d_q;
  assign cs_rise = cs_s[1] && !cs_d_q;
  assign cs_fall = !cs_s[1] && cs_d_q;

  // fixed variants never look at the strap pin
  assign x16_now = (ORG_MODE == see_pkg::ORG_FIX16) ? 1'b1 :
                   (ORG_MODE == see_pkg::ORG_FIX8)  ? 1'b0 :
                   org_s[1];
  assign wbits_m1 = x16_q ? 5'(see_pkg::WBITS16 - 1)
                          : 5'(see_pkg::WBITS8 - 1);
  // x16 word address is shifted one place to form the byte address
  assign nxt_addr  = {addr_q[AW-2:0], di_s[1]};
  assign nxt_baddr = x16_q ? {nxt_addr[AW-2:0], 1'b0} : nxt_addr;
  assign rd_word   = x16_q ? {mem_q[baddr_q], mem_q[baddr_q + 1'b1]}
                           : {mem_q[baddr_q], 8'h00};
  assign busy = cmt_q || f_out_vld || (timer_q != '0);
  assign push = cs_fall && cmt_q;

  // select low time, counted from its fall
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cslow_q <= '0;
    end else if (cs_fall) begin
      cslow_q <= 8'h01;
    end else if (!cs_s[1] && cslow_q != 8'hff) begin
      cslow_q <= cslow_q + 8'h01;
    end
  end

  // instruction sequencer; held in reset while select is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= see_pkg::ST_IDLE;
      cnt_q    <= '0;
      x16_q    <= 1'b0;
      opc_q    <= '0;
      addr_q   <= '0;
      baddr_q  <= '0;
      wd_q     <= '0;
      sh_q     <= '0;
      ld_q     <= 1'b0;
      rd_on_q  <= 1'b0;
      rd_bit_q <= 1'b0;
    end else if (!cs_s[1]) begin
      st_q    <= see_pkg::ST_IDLE;
      cnt_q   <= '0;
      ld_q    <= 1'b0;
      rd_on_q <= 1'b0;
    end else if (ld_q) begin
      ld_q <= 1'b0;
      sh_q <= rd_word;
    end else if (rise) begin
      case (st_q)
        see_pkg::ST_IDLE: begin
          // a start bit is refused while programming or queue full
          if (di_s[1] && !busy && f_in_rdy) begin
            x16_q <= x16_now;
            cnt_q <= '0;
            st_q  <= see_pkg::ST_OPC;
          end
        end
        see_pkg::ST_OPC: begin
          opc_q <= {opc_q[0], di_s[1]};
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == 5'd1) begin
            cnt_q <= '0;
            st_q  <= see_pkg::ST_ADDR;
          end
        end
        see_pkg::ST_ADDR: begin
          addr_q <= nxt_addr;
          cnt_q  <= cnt_q + 5'd1;
          if (cnt_q == 5'(x16_q ? AW - 2 : AW - 1)) begin
            baddr_q <= nxt_baddr;
            cnt_q   <= '0;
            if (opc_q == see_pkg::OP_READ) begin
              st_q     <= see_pkg::ST_READ;
              ld_q     <= 1'b1;
              rd_on_q  <= 1'b1;
              rd_bit_q <= 1'b0;
            end else if (opc_q == see_pkg::OP_WRITE) begin
              st_q <= see_pkg::ST_WDATA;
            end else begin
              // erase has no data; other codes are ignored
              wd_q <= see_pkg::ERASED_WORD;
              st_q <= see_pkg::ST_DONE;
            end
          end
        end
        see_pkg::ST_WDATA: begin
          wd_q  <= {wd_q[14:0], di_s[1]};
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == wbits_m1) st_q <= see_pkg::ST_DONE;
        end
        see_pkg::ST_READ: begin
          // bit leaves on each rising edge, msb first
          rd_bit_q <= sh_q[15];
          sh_q     <= {sh_q[14:0], 1'b0};
          cnt_q    <= cnt_q + 5'd1;
          if (cnt_q == wbits_m1) begin
            // sequential read rolls on to the next location
            cnt_q   <= '0;
            baddr_q <= baddr_q + (x16_q ? AW'(2) : AW'(1));
            ld_q    <= 1'b1;
          end
        end
        default: begin
          // done: clock and data are ignored until select falls
        end
      endcase
    end
  end

  // program request waits for the select fall that initiates it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmt_q <= 1'b0;
    end else if (cs_fall) begin
      cmt_q <= 1'b0;
    end else if (cs_s[1] && rise && st_q == see_pkg::ST_ADDR &&
                 cnt_q == 5'(x16_q ? AW - 2 : AW - 1) &&
                 opc_q == see_pkg::OP_ERASE) begin
      cmt_q <= 1'b1;
    end else if (cs_s[1] && rise && st_q == see_pkg::ST_WDATA &&
                 cnt_q == wbits_m1) begin
      cmt_q <= 1'b1;
    end
  end

  assign f_in = {x16_q, baddr_q, wd_q};

  see_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .in_valid_i (push),
    .in_ready_o (f_in_rdy),
    .in_data_i  (f_in),
    .out_valid_o(f_out_vld),
    .out_ready_i(f_out_rdy),
    .out_data_o (f_out)
  );

  // the engine stalls the queue while a cycle runs
  assign f_out_rdy = (timer_q == '0);

  // self-timed programming cycle, runs whatever select does
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_q <= '0;
      prog_q  <= '0;
    end else if (timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end else if (f_out_vld) begin
      timer_q <= ($clog2(PROG_CYC+1))'(PROG_CYC);
      prog_q  <= f_out;
    end
  end

  // array update at the end of the cycle
  always_ff @(posedge ref_clk_i) begin
    if (timer_q == 1) begin
      if (prog_q[FW-1]) begin
        mem_q[prog_q[AW+15:16]]        <= prog_q[15:8];
        mem_q[prog_q[AW+15:16] + 1'b1] <= prog_q[7:0];
      end else begin
        mem_q[prog_q[AW+15:16]] <= prog_q[7:0];
      end
    end
  end

  // status: pending flag, display and clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q    <= 1'b0;
      stat_q    <= 1'b0;
      clr_arm_q <= 1'b0;
    end else begin
      if (cs_fall) begin
        stat_q    <= 1'b0;
        clr_arm_q <= 1'b0;
        // a new program wins over the clear
        if (push) pend_q <= 1'b1;
        else if (clr_arm_q && !busy) pend_q <= 1'b0;
      end else if (cs_rise && pend_q &&
                   cslow_q >= 8'(see_pkg::CS_LOW_MIN_CYC)) begin
        stat_q <= 1'b1;
      end else if (stat_q && rise && di_s[1] && !busy) begin
        stat_q    <= 1'b0;
        clr_arm_q <= 1'b1;
      end
    end
  end

  // pin driver: status low while busy, high when ready, read bits while reading, else floating
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      do_q    <= 1'b0;
      do_oe_q <= 1'b0;
    end else begin
      do_oe_q <= cs_s[1] && (stat_q || rd_on_q);
      do_q    <= stat_q ? !busy : rd_bit_q;
    end
  end

  assign do_o    = do_q;
  assign do_oe_o = do_oe_q;
endmodule

// file: testbench/see_master.sv
// bus master model: drives select, link clock and serial data
module see_master (
  // pins towards the device
  output logic      cs_o,
  output logic      sclk_o,
  output logic      di_o,
  // resolved serial data output of the device
  input  wire logic do_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // link clock parked low outside frames
  initial begin
    cs_o   = 1'b0;
    sclk_o = 1'b0;
    di_o   = 1'b0;
  end

  // raise select, leave time for its synchroniser
  task automatic select();
    cs_o = 1'b1;
    #40;
  endtask

  // drop select; data line no longer meaningful, so show the inverse
  task automatic deselect();
    cs_o = 1'b0;
    di_o = ~di_o;
    #300;
  endtask

  // n bits msb first at 125 ns a bit, sampling the reply late in each bit
  task automatic shift(input logic [31:0] v, input int n,
                       output logic [31:0] got);
    got = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      di_o = v[i];
      #31 sclk_o = 1'b1;
      #62 sclk_o = 1'b0;
      #30 got = {got[30:0], do_i};
      #2;
    end
  endtask
endmodule

// file: testbench/see_chk.sv
// pin-level checks on the serial data output
module see_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // serial pins and strap
  input wire logic cs_i,
  input wire logic sclk_i,
  input wire logic serial_data_in_i,
  input wire logic word_width_strap_i,
  // tri-state output pair
  input wire logic do_o,
  input wire logic do_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // deselect long enough to get through the select synchroniser
  sequence desel_s;
    !cs_i [*6];
  endsequence
  // selected, link clock parked, nothing driven
  sequence quiet_s;
    (cs_i && !sclk_i && !do_oe_o) [*8];
  endsequence
  // selected and link clock parked long past any output delay
  sequence park_s;
    (cs_i && !sclk_i) [*8] ##1 (do_oe_o && $past(do_oe_o));
  endsequence

  chk_reset_quiet:
    assert property (disable iff (1'b0) !rst_n_i |-> !do_oe_o)
    else $error("output enabled during reset");
  chk_release_quiet:
    assert property ($rose(rst_n_i) |-> !do_oe_o ##1 !do_oe_o)
    else $error("output enabled right after reset");
  chk_desel_quiet:
    assert property (desel_s |-> !do_oe_o)
    else $error("output driven while deselected");
  chk_oe_drops:
    assert property ($fell(cs_i) |-> ##[3:6] !do_oe_o)
    else $error("output still driven after select fell");
  chk_oe_after_sel:
    assert property ($rose(do_oe_o) |-> $past(cs_i, 3))
    else $error("output enabled without select");
  chk_fall_on_clk:
    assert property ($fell(do_o) && do_oe_o && $past(do_oe_o) |->
      $past(sclk_i, 3) || $past(sclk_i, 4) || $past(sclk_i, 5))
    else $error("data fell without a link clock rise");
  chk_park_hold:
    assert property (park_s |-> !$fell(do_o))
    else $error("data fell while link clock parked");
  chk_idle_stays:
    assert property (quiet_s |=> !do_oe_o)
    else $error("output enabled with no cause");
endmodule

bind see_top see_chk i_chk (
  .ref_clk_i          (ref_clk_i),
  .rst_n_i            (rst_n_i),
  .cs_i               (cs_i),
  .sclk_i             (sclk_i),
  .serial_data_in_i   (serial_data_in_i),
  .word_width_strap_i (word_width_strap_i),
  .do_o               (do_o),
  .do_oe_o            (do_oe_o)
);

// file: testbench/test_serial_eeprom_pin_data_status.sv
// serial memory slave bench: master model on the link side
module test_serial_eeprom_pin_data_status;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset, strap
  logic ref_clk = 1'b0;
  logic rst_n   = 1'b0;
  logic strap   = 1'b0;
  // link pins
  logic cs;
  logic sclk;
  logic di;
  logic do_v;
  logic do_oe;
  // pin level as the master sees it
  wire  do_pin  = do_oe ? do_v : 1'bz;
  // bookkeeping
  int   n_errors    = 0;
  int   check_count = 0;
  int   cyc         = 0;

  always #4 ref_clk = ~ref_clk;

  // programming time shortened so status is seen busy, then ready
  see_top #(.PROG_CYC(100)) i_dut (
    .ref_clk_i          (ref_clk),
    .rst_n_i            (rst_n),
    .cs_i               (cs),
    .sclk_i             (sclk),
    .serial_data_in_i   (di),
    .word_width_strap_i (strap),
    .do_o               (do_v),
    .do_oe_o            (do_oe)
  );

  see_master i_mst (
    .cs_o   (cs),
    .sclk_o (sclk),
    .di_o   (di),
    .do_i   (do_pin)
  );

  // hang guard, far above the expected run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // commit a program, watch busy then ready, then clear the status
  task automatic prog(input logic [31:0] v, input int n);
    logic [31:0] g;
    // select first: a deselected device holds its sequencer in reset
    i_mst.select();
    i_mst.shift(v, n, g);
    i_mst.deselect();
    i_mst.select();
    #16 check("busy enable", do_oe, 32'h1);
    check("busy level", do_v, 32'h0);
    #1000 check("ready level", do_v, 32'h1);
    i_mst.shift(32'h1, 1, g);
    i_mst.deselect();
    i_mst.select();
    #16 check("cleared", do_oe, 32'h0);
    i_mst.deselect();
  endtask

  // read w bits after the dummy, then deselect
  task automatic rd(input logic [31:0] v, input int n, input int w,
                    input logic [31:0] exp);
    logic [31:0] g;
    i_mst.select();
    i_mst.shift(v, n, g);
    check("dummy bit", g[w], 32'h0);
    check("read data", g & ((32'h1 << w) - 1), exp);
    i_mst.deselect();
    check("deselected", do_oe, 32'h0);
  endtask

  task automatic t_x8();
    prog({1'b1, see_pkg::OP_WRITE, 8'h5a, 8'ha5}, 19);
    rd({1'b1, see_pkg::OP_READ, 8'h5a, 8'h00}, 19, 8, 32'ha5);
    $display("t_x8 done");
  endtask

  // select held low through the whole cycle, then sequential read
  task automatic t_hold();
    logic [31:0] g;
    i_mst.select();
    i_mst.shift({1'b1, see_pkg::OP_WRITE, 8'h5b, 8'h3c}, 19, g);
    i_mst.deselect();
    #1000 check("low hold", do_oe, 32'h0);
    i_mst.select();
    #16 check("late status", {do_oe, do_v}, 32'h3);
    i_mst.shift(32'h1, 1, g);
    i_mst.deselect();
    rd({1'b1, see_pkg::OP_READ, 8'h5a, 16'h0}, 27, 16, 32'ha53c);
    $display("t_hold done");
  endtask

  task automatic t_erase();
    prog({1'b1, see_pkg::OP_ERASE, 8'h5a}, 11);
    rd({1'b1, see_pkg::OP_READ, 8'h5a, 8'h00}, 19, 8,
       {24'h0, see_pkg::ERASED_WORD[7:0]});
    $display("t_erase done");
  endtask

  // strap moved only while deselected, word seen as two bytes
  task automatic t_x16();
    @(posedge ref_clk);
    #1 strap = 1'b1;
    prog({1'b1, see_pkg::OP_WRITE, 7'h12, 16'hbeef}, 26);
    rd({1'b1, see_pkg::OP_READ, 7'h12, 16'h0}, 26, 16, 32'hbeef);
    @(posedge ref_clk);
    #1 strap = 1'b0;
    rd({1'b1, see_pkg::OP_READ, 8'h24, 16'h0}, 27, 16, 32'hbeef);
    $display("t_x16 done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    t_x8();
    t_hold();
    t_erase();
    t_x16();
    give_verdict();
  end
endmodule
